// ==== src/tcc_ctrl.sv ====
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "tcc_defines.svh"

// Behaviour
// (R1) Read select accepts only count and captures
// (R2) Clear and set views share one state
// (R3) Command runs on next tick, then reads zero
// (R4) Command codes: none, retrigger, stop, reserved
// (R5) Clear view ones cancel pending command
// (R6) Set view ones place pending command
// (R7) Written zeros leave control state unchanged
// (R8) Single pass stops at next wrap
// (R9) Set view enables, clear view disables single
// (R10) Direction zero up, one down
// (R11) Capture enable selects capture or compare
// (R12) Invert bit inverts waveform pin
// (R13) Debug halt stops counter unless run bit
// (R14) Debug run bit survives software reset
// (R15) Software leaves debug run alone while enabled; debug register writes are not blocked while enabled
// (R16) Channel event out gated by enable
// (R17) Wrap event out gated by enable
// (R18) Input events accepted only when enabled
// (R19) Event register locked while unit enabled
// (R20) Control B writes pass synchroniser, reads do not
// (R21) Read trigger starts sync, sets busy
// (R22) Polarity bit inverts incoming event
// (R23) Event action codes select event behaviour
// (R24) Retrigger restarts from bottom or top; stop holds

module tcc_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Register port
    input tcc_pkg::tcc_bus_req_s bus_i,
    output logic [15:0] rdata_o,
    // System and event inputs
    input wire logic debug_halt_i,
    input wire logic event_in_i,
    // Waveform, event and sync busy outputs
    output logic [1:0] channel_waveform_pin_o,
    output logic wrap_event_o,
    output logic [1:0] channel_event_o,
    output logic sync_in_progress_flag_o
);
    import tcc_pkg::*;

    // ****************************************
    // State and working signals
    // ****************************************
    tcc_state_s st;
    tcc_state_s next_st;
    logic run_ok;
    logic tick;
    logic step;
    logic wrap;
    logic ev_lvl;
    logic ev_rise;
    logic ev_fall;
    logic ev_ok;
    logic [2:0] act;
    logic busy;
    logic sync_done;
    logic swrst;
    logic rsel_ok;
    logic pch;
    logic [15:0] restart;
    logic [7:0] cb_view;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_st = st;
        run_ok = !debug_halt_i || st.run_during_debug_halt; // R13
        busy = (st.sync_cnt != 4'h0);
        sync_done = (st.sync_cnt == 4'h1);
        swrst = bus_i.we && (bus_i.addr == `TCC_ADDR_CTRL) && bus_i.wdata[`TCC_CA_SWRST];
        ev_lvl = st.ev_s2 ^ st.event_io_control[`TCC_EV_INPOL]; // R22
        ev_rise = ev_lvl && !st.ev_d;
        ev_fall = !ev_lvl && st.ev_d;
        ev_ok = st.enable && run_ok && st.event_io_control[`TCC_EV_INEN]; // R18
        act = st.event_io_control[`TCC_EV_ACT];
        tick = st.enable && run_ok && (st.presc == `TCC_PRESC_LAST);
        step = st.running && ((act == `TCC_ACT_COUNT) ? (ev_ok && ev_rise) : tick); // R23
        wrap = step && (st.dir ? (st.count == `TCC_RST_WORD) : (st.count == `TCC_TOP));
        restart = st.dir ? `TCC_TOP : `TCC_RST_WORD; // R24
        rsel_ok = (bus_i.wdata[`TCC_RS_SEL] == `TCC_ADDR_COUNT) ||
                  (bus_i.wdata[`TCC_RS_SEL] == `TCC_ADDR_CAP0) ||
                  (bus_i.wdata[`TCC_RS_SEL] == `TCC_ADDR_CAP1);
        pch = (act == `TCC_ACT_PWP);
        cb_view = {st.cmd, 3'h0, st.single, 1'b0, st.dir};

        // Input synchroniser and edge history
        next_st.ev_s1 = event_in_i;
        next_st.ev_s2 = st.ev_s1;
        next_st.ev_d = ev_lvl;
        next_st.ovf_ev = 1'b0;
        next_st.mc_ev = 2'h0;

        // Prescaler makes the counter tick enable
        if (st.enable && run_ok)
        begin
            next_st.presc = (st.presc == `TCC_PRESC_LAST) ? 8'h00 : st.presc + 8'h01;
        end

        // Counting, wrap and compare matches
        if (step)
        begin
            next_st.count = st.dir ? st.count - 16'h0001 : st.count + 16'h0001; // R10
            if (wrap)
            begin
                next_st.ovf_ev = st.event_io_control[`TCC_EV_WRAP_EVENT_OUT_ENABLE]; // R17
                if (st.single)
                begin
                    next_st.running = 1'b0; // R8
                end
            end
            for (int n = 0; n < 2; n++)
            begin
                if (!st.cpt[n] && (st.count == st.cap[n])) // R11
                begin
                    next_st.wave[n] = !st.wave[n];
                    next_st.mc_ev[n] = st.event_io_control[`TCC_EV_CHEO_LO + n]; // R16
                end
            end
        end

        // Incoming event actions
        if (ev_ok && (ev_rise || ev_fall))
        begin
            case (act) // R23
                `TCC_ACT_RETRIG:
                begin
                    if (ev_rise)
                    begin
                        next_st.count = restart;
                        next_st.running = 1'b1;
                    end
                end
                `TCC_ACT_START:
                begin
                    if (ev_rise)
                    begin
                        next_st.running = 1'b1;
                    end
                end
                `TCC_ACT_PPW, `TCC_ACT_PWP:
                begin
                    // Period on the rising edge, pulse width on the falling one
                    if (ev_rise && st.cpt[pch])
                    begin
                        next_st.cap[pch] = st.count;
                        next_st.mc_ev[pch] = st.event_io_control[`TCC_EV_CHEO_LO + pch]; // R16
                    end
                    if (ev_fall && st.cpt[!pch])
                    begin
                        next_st.cap[!pch] = st.count;
                        next_st.mc_ev[!pch] = st.event_io_control[`TCC_EV_CHEO_LO + !pch];
                    end
                    if (ev_rise)
                    begin
                        next_st.count = `TCC_RST_WORD;
                        next_st.running = 1'b1;
                    end
                end
                default:
                begin
                    for (int n = 0; n < 2; n++)
                    begin
                        if (ev_rise && st.cpt[n]) // R11
                        begin
                            next_st.cap[n] = st.count;
                            next_st.mc_ev[n] = st.event_io_control[`TCC_EV_CHEO_LO + n];
                        end
                    end
                end
            endcase
        end

        // Pending command runs on the prescaled tick
        if (tick)
        begin
            case (st.cmd) // R4
                `TCC_CMD_RETRIG:
                begin
                    next_st.count = restart; // R24
                    next_st.running = 1'b1;
                end
                `TCC_CMD_STOP:
                begin
                    next_st.running = 1'b0; // R24
                end
                default:
                begin
                    next_st.running = next_st.running;
                end
            endcase
            next_st.cmd = `TCC_CMD_NONE; // R3
        end

        // Synchroniser countdown; completion applied after the command clear
        if (busy)
        begin
            next_st.sync_cnt = st.sync_cnt - 4'h1;
        end
        if (sync_done && st.sync_rd)
        begin
            next_st.rdsync = (st.rsel == `TCC_ADDR_COUNT) ? st.count :
                             (st.rsel == `TCC_ADDR_CAP0) ? st.cap[0] : st.cap[1]; // R21
        end
        else if (sync_done && st.pend_set)
        begin
            if (st.pend_val[`TCC_CB_CMD] != `TCC_CMD_NONE)
            begin
                next_st.cmd = st.pend_val[`TCC_CB_CMD]; // R6
            end
            next_st.single = st.single || st.pend_val[`TCC_CB_SINGLE]; // R9
            next_st.dir = st.dir || st.pend_val[`TCC_CB_DIR]; // R10
        end
        else if (sync_done)
        begin
            if (st.pend_val[`TCC_CB_CMD] != `TCC_CMD_NONE)
            begin
                next_st.cmd = `TCC_CMD_NONE; // R5
            end
            next_st.single = st.single && !st.pend_val[`TCC_CB_SINGLE]; // R9
            next_st.dir = st.dir && !st.pend_val[`TCC_CB_DIR]; // R7
        end

        // Register writes
        if (bus_i.we)
        begin
            if (bus_i.addr == `TCC_ADDR_CTRL)
            begin
                next_st.enable = bus_i.wdata[`TCC_CA_EN];
                if (bus_i.wdata[`TCC_CA_EN] && !st.enable)
                begin
                    next_st.running = 1'b1;
                    next_st.presc = 8'h00;
                end
            end
            else if (bus_i.addr == `TCC_ADDR_RSYNC)
            begin
                if (rsel_ok)
                begin
                    next_st.rsel = bus_i.wdata[`TCC_RS_SEL]; // R1
                end
                if (bus_i.wdata[`TCC_RS_TRIG] && rsel_ok && !busy)
                begin
                    next_st.sync_rd = 1'b1; // R21
                    next_st.sync_cnt = `TCC_SYNC_CYC;
                end
            end
            else if ((bus_i.addr == `TCC_ADDR_CBCLR) || (bus_i.addr == `TCC_ADDR_CBSET))
            begin
                if (!busy)
                begin
                    next_st.pend_val = bus_i.wdata[7:0]; // R20
                    next_st.pend_set = (bus_i.addr == `TCC_ADDR_CBSET); // R2
                    next_st.sync_rd = 1'b0;
                    next_st.sync_cnt = `TCC_SYNC_CYC;
                end
            end
            else if (bus_i.addr == `TCC_ADDR_CHCTL)
            begin
                next_st.cpt = bus_i.wdata[`TCC_CH_CPT];
                next_st.inv = bus_i.wdata[`TCC_CH_INV];
            end
            else if (bus_i.addr == `TCC_ADDR_DBG)
            begin
                next_st.run_during_debug_halt = bus_i.wdata[`TCC_DBG_RUN];
            end
            else if (bus_i.addr == `TCC_ADDR_EVIO)
            begin
                if (!st.enable)
                begin
                    next_st.event_io_control = bus_i.wdata & `TCC_EV_MASK; // R19
                end
            end
            else if (bus_i.addr == `TCC_ADDR_CAP0)
            begin
                next_st.cap[0] = bus_i.wdata;
            end
            else if (bus_i.addr == `TCC_ADDR_CAP1)
            begin
                next_st.cap[1] = bus_i.wdata;
            end
        end

        // Software reset wins over everything but the debug run bit and the data of a read in the same cycle
        if (swrst)
        begin
            next_st = '0;
            next_st.run_during_debug_halt = st.run_during_debug_halt; // R14
        end

        // Register reads, data valid in the following cycle
        next_st.rdata = `TCC_RST_WORD;
        if (bus_i.re)
        begin
            if (bus_i.addr == `TCC_ADDR_CTRL)
            begin
                next_st.rdata = {14'h0000, st.enable, 1'b0};
            end
            else if (bus_i.addr == `TCC_ADDR_RSYNC)
            begin
                next_st.rdata = {11'h000, st.rsel};
            end
            else if ((bus_i.addr == `TCC_ADDR_CBCLR) || (bus_i.addr == `TCC_ADDR_CBSET))
            begin
                next_st.rdata = {8'h00, cb_view}; // R2
            end
            else if (bus_i.addr == `TCC_ADDR_CHCTL)
            begin
                next_st.rdata = {10'h000, st.cpt, 2'h0, st.inv};
            end
            else if (bus_i.addr == `TCC_ADDR_DBG)
            begin
                next_st.rdata = {15'h0000, st.run_during_debug_halt};
            end
            else if (bus_i.addr == `TCC_ADDR_EVIO)
            begin
                next_st.rdata = st.event_io_control;
            end
            else if (bus_i.addr == `TCC_ADDR_STATUS)
            begin
                next_st.rdata = {8'h00, busy, 7'h00};
            end
            else if (bus_i.addr == `TCC_ADDR_COUNT)
            begin
                next_st.rdata = st.rdsync;
            end
            else if (bus_i.addr == `TCC_ADDR_CAP0)
            begin
                next_st.rdata = st.cap[0];
            end
            else if (bus_i.addr == `TCC_ADDR_CAP1)
            begin
                next_st.rdata = st.cap[1];
            end
        end

        // Registered waveform pins
        next_st.wo = next_st.wave ^ next_st.inv; // R12
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs
    assign rdata_o = st.rdata;
    assign channel_waveform_pin_o = st.wo;
    assign wrap_event_o = st.ovf_ev;
    assign channel_event_o = st.mc_ev;
    assign sync_in_progress_flag_o = busy;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb_main @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_cmd_clears: assert property (tick && (st.cmd != 2'h0) && !sync_done && !swrst
        |=> (st.cmd == 2'h0)) else $error("command not cleared after tick"); // R3
    a_evio_locked: assert property (bus_i.we && (bus_i.addr == `TCC_ADDR_EVIO) && st.enable
        && !swrst |=> $stable(st.event_io_control)) else $error("event register changed while enabled"); // R19
    a_read_sync_busy: assert property (bus_i.we && (bus_i.addr == `TCC_ADDR_RSYNC) && !busy
        && bus_i.wdata[15] && rsel_ok |=> sync_in_progress_flag_o ##1 sync_in_progress_flag_o)
        else $error("read trigger did not set busy"); // R21
    a_sync_length: assert property ($rose(sync_in_progress_flag_o) |->
        sync_in_progress_flag_o [*3] ##1 !sync_in_progress_flag_o)
        else $error("sync busy length wrong"); // R20
    a_pin_invert: assert property (bus_i.we && (bus_i.addr == `TCC_ADDR_CHCTL) |=>
        (channel_waveform_pin_o == (st.wave ^ $past(bus_i.wdata[1:0]))))
        else $error("waveform pin polarity wrong"); // R12
    a_wrap_gate: assert property (wrap_event_o |-> $past(st.event_io_control[8]) && $past(wrap))
        else $error("wrap event without enable"); // R17
    a_chan_gate: assert property ((channel_event_o != 2'h0) |->
        (($past(st.event_io_control[13:12]) & channel_event_o) == channel_event_o))
        else $error("channel event without enable"); // R16
    a_debug_hold: assert property (debug_halt_i && !st.run_during_debug_halt && !swrst |=> $stable(st.count))
        else $error("counter moved during debug halt"); // R13
    a_dbg_keep: assert property (swrst |=> $stable(st.run_during_debug_halt) && !st.enable)
        else $error("debug run lost in software reset"); // R14
    a_single_stop: assert property (wrap && st.single && !ev_ok && (st.cmd != 2'h1) && !bus_i.we
        |=> !st.running) else $error("single pass did not stop"); // R8
    a_set_cmd: assert property (sync_done && !st.sync_rd && st.pend_set && !swrst
        && (st.pend_val[7:6] != 2'h0) |=> (st.cmd == $past(st.pend_val[7:6])))
        else $error("set view did not place command"); // R6

endmodule : tcc_ctrl

// ==== src/tcc_defines.svh ====
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define TCC_ADDR_CTRL 8'h00
`define TCC_ADDR_RSYNC 8'h02
`define TCC_ADDR_CBCLR 8'h04
`define TCC_ADDR_CBSET 8'h05
`define TCC_ADDR_CHCTL 8'h06
`define TCC_ADDR_DBG 8'h08
`define TCC_ADDR_EVIO 8'h0a
`define TCC_ADDR_STATUS 8'h0f
`define TCC_ADDR_COUNT 8'h10
`define TCC_ADDR_CAP0 8'h18
`define TCC_ADDR_CAP1 8'h1a

// ****************************************
// Field positions
// ****************************************
`define TCC_CA_SWRST 0
`define TCC_CA_EN 1
`define TCC_RS_TRIG 15
`define TCC_RS_SEL 4:0
`define TCC_CB_CMD 7:6
`define TCC_CB_SINGLE 2
`define TCC_CB_DIR 0
`define TCC_CH_CPT 5:4
`define TCC_CH_INV 1:0
`define TCC_DBG_RUN 0
`define TCC_EV_CHEO 13:12
`define TCC_EV_CHEO_LO 12
`define TCC_EV_WRAP_EVENT_OUT_ENABLE 8
`define TCC_EV_INEN 5
`define TCC_EV_INPOL 4
`define TCC_EV_ACT 2:0
`define TCC_EV_MASK 16'h3133
`define TCC_ST_BUSY 7

// ****************************************
// Encodings, reset values and timing
// ****************************************
`define TCC_CMD_NONE 2'h0
`define TCC_CMD_RETRIG 2'h1
`define TCC_CMD_STOP 2'h2
`define TCC_ACT_RETRIG 3'h1
`define TCC_ACT_COUNT 3'h2
`define TCC_ACT_START 3'h3
`define TCC_ACT_PPW 3'h5
`define TCC_ACT_PWP 3'h6
`define TCC_RST_WORD 16'h0000
`define TCC_TOP 16'hffff
`define TCC_PRESC_LAST 8'h03
`define TCC_SYNC_CYC 4'h3

`endif

// ==== src/tcc_pkg.sv ====
package tcc_pkg;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic we;
        logic re;
    } tcc_bus_req_s;

    // Whole state of the control block
    typedef struct packed {
        logic enable;
        logic running;
        logic [1:0] cmd;
        logic single;
        logic dir;
        logic [1:0] cpt;
        logic [1:0] inv;
        logic run_during_debug_halt;
        logic [15:0] event_io_control;
        logic [4:0] rsel;
        logic [15:0] count;
        logic [1:0][15:0] cap;
        logic [1:0] wave;
        logic [1:0] wo;
        logic [7:0] presc;
        logic [3:0] sync_cnt;
        logic sync_rd;
        logic pend_set;
        logic [7:0] pend_val;
        logic [15:0] rdsync;
        logic ev_s1;
        logic ev_s2;
        logic ev_d;
        logic ovf_ev;
        logic [1:0] mc_ev;
        logic [15:0] rdata;
    } tcc_state_s;

endpackage : tcc_pkg

// ==== verif/tcc_evt_src.sv ====
`timescale 1ns/100ps

// ****************************************
// Event system source model
// ****************************************
module tcc_evt_src (
    // Clock and request
    input wire logic clk_i,
    input wire logic fire_i,
    // Asynchronous event line, idles low
    output logic event_o
);
    logic [2:0] hold = 3'h0;

    // Each request drives the line high for six cycles, then lets it fall
    always @(posedge clk_i)
    begin
        if (fire_i)
            hold <= 3'h6;
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
    end
    assign event_o = (hold != 3'h0);
endmodule : tcc_evt_src

// ==== verif/tcc_ctrl_tb_top.sv ====
`timescale 1ns/100ps
`include "tcc_defines.svh"

module tcc_ctrl_tb_top;
    import tcc_pkg::*;

    // ****************************************
    // Stimulus, observation and instances
    // ****************************************
    logic clk_i, arst_n_i, halt, fire, ev_pin, wrap, busy;
    tcc_bus_req_s bus;
    logic [15:0] rdata, a, b;
    logic [1:0] pins, chev;
    int error_cnt, num_checks, cycles, wrap_cnt, ch0_cnt;

    tcc_ctrl u_tcc_ctrl (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .bus_i(bus),
        .rdata_o(rdata),
        .debug_halt_i(halt),
        .event_in_i(ev_pin),
        .channel_waveform_pin_o(pins),
        .wrap_event_o(wrap),
        .channel_event_o(chev),
        .sync_in_progress_flag_o(busy)
    );

    tcc_evt_src u_tcc_evt_src (
        .clk_i(clk_i),
        .fire_i(fire),
        .event_o(ev_pin)
    );

    // Clock at 25 ns
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Pulse counters and hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (wrap === 1'b1) wrap_cnt++;
        if (chev[0] === 1'b1) ch0_cnt++;
        if (cycles == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end

    // ****************************************
    // Access and comparison tasks
    // ****************************************
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task wr(input logic [7:0] ad, input logic [15:0] d);
        @(posedge clk_i);
        bus <= '{ad, d, 1'b1, 1'b0};
        @(posedge clk_i);
        bus.we <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] ad, output logic [15:0] d);
        @(posedge clk_i);
        bus <= '{ad, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_i);
        bus.re <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task sync_wait;
        int n;
        n = 0;
        #1;
        while (busy !== 1'b0 && n < 20)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check("busy end", {15'h0000, busy}, 16'h0000);
        repeat (2) @(posedge clk_i);
    endtask : sync_wait

    // Control B write, which must go through the synchroniser
    task wcb(input logic [7:0] ad, input logic [15:0] d);
        wr(ad, d);
        #1;
        check("busy start", {15'h0000, busy}, 16'h0001);
        sync_wait();
    endtask : wcb

    // Counter snapshot through a read request
    task snap(output logic [15:0] d);
        wr(`TCC_ADDR_RSYNC, 16'h8010);
        sync_wait();
        rd(`TCC_ADDR_COUNT, d);
    endtask : snap

    task swrst;
        wr(`TCC_ADDR_CTRL, 16'h0001);
        @(posedge clk_i);
    endtask : swrst

    task tend(input string name);
        $display("test %s done", name);
    endtask : tend

    task wrap_run(input logic [15:0] ev, input logic [15:0] n);
        swrst();
        wr(`TCC_ADDR_EVIO, ev);
        wcb(`TCC_ADDR_CBSET, 16'h0005);
        wrap_cnt = 0;
        wr(`TCC_ADDR_CTRL, 16'h0002);
        repeat (30) @(posedge clk_i);
        check("wrap events", wrap_cnt[15:0], n);
        snap(a);
        check("single pass count", a, 16'hffff);
        tend("wrap");
    endtask : wrap_run

    // Halted counter sits at zero; events are refused while halted, so the
    // halt is lifted before firing. Count-on-event holds the count at zero until the event, which captures zero.
    task ev_run(input logic [15:0] ev, input logic [15:0] exp);
        swrst();
        wr(`TCC_ADDR_DBG, 16'h0000);
        wr(`TCC_ADDR_CAP0, 16'h1234);
        wr(`TCC_ADDR_CHCTL, 16'h0010);
        wr(`TCC_ADDR_EVIO, ev);
        halt <= 1'b1;
        wr(`TCC_ADDR_CTRL, 16'h0002);
        snap(a);
        check("halted count", a, 16'h0000);
        @(posedge clk_i);
        halt <= 1'b0;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (12) @(posedge clk_i);
        rd(`TCC_ADDR_CAP0, b);
        check("capture 0", b, exp);
        tend("event in");
    endtask : ev_run

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        logic [7:0] regs [5];
        regs = '{`TCC_ADDR_CBCLR, `TCC_ADDR_CBSET, `TCC_ADDR_CHCTL, `TCC_ADDR_DBG, `TCC_ADDR_EVIO};
        arst_n_i = 1'b0;
        bus = '0;
        halt = 1'b0;
        fire = 1'b0;
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        foreach (regs[i])
        begin
            rd(regs[i], a);
            check("reset value", a, 16'h0000);
        end
        tend("reset");
        // Set and clear views on the shared state, unit disabled
        wcb(`TCC_ADDR_CBSET, 16'h0005);
        rd(`TCC_ADDR_CBCLR, a);
        check("set dir single", a, 16'h0005);
        wcb(`TCC_ADDR_CBSET, 16'h0000);
        rd(`TCC_ADDR_CBSET, a);
        check("zero write", a, 16'h0005);
        wcb(`TCC_ADDR_CBCLR, 16'h0004);
        wcb(`TCC_ADDR_CBSET, 16'h0040);
        rd(`TCC_ADDR_CBSET, a);
        check("pending cmd", a, 16'h0041);
        wcb(`TCC_ADDR_CBCLR, 16'h0080);
        rd(`TCC_ADDR_CBSET, a);
        check("cancel cmd", a, 16'h0001);
        wcb(`TCC_ADDR_CBCLR, 16'h0001);
        rd(`TCC_ADDR_CBCLR, a);
        check("clear dir", a, 16'h0000);
        tend("views");
        // Stop holds the count, retrigger restarts near zero
        wr(`TCC_ADDR_CTRL, 16'h0002);
        repeat (200) @(posedge clk_i);
        wcb(`TCC_ADDR_CBSET, 16'h0080);
        repeat (12) @(posedge clk_i);
        rd(`TCC_ADDR_CBSET, a);
        check("cmd done", a, 16'h0000);
        snap(a);
        repeat (20) @(posedge clk_i);
        snap(b);
        check("stop holds", {15'h0000, b == a}, 16'h0001);
        check("count ran", {15'h0000, a > 16'h0020}, 16'h0001);
        wcb(`TCC_ADDR_CBSET, 16'h0040);
        wcb(`TCC_ADDR_CBSET, 16'h0080);
        repeat (12) @(posedge clk_i);
        snap(b);
        check("retrigger", {15'h0000, b < 16'h0008}, 16'h0001);
        tend("commands");
        // Read select refuses a non-counter target
        wr(`TCC_ADDR_RSYNC, 16'h8006);
        repeat (2) @(posedge clk_i);
        check("bad select", {15'h0000, busy}, 16'h0000);
        rd(`TCC_ADDR_STATUS, a);
        check("status", a, 16'h0000);
        tend("select");
        // Event register locked while enabled
        wr(`TCC_ADDR_EVIO, 16'hffff);
        rd(`TCC_ADDR_EVIO, a);
        check("locked", a, 16'h0000);
        wr(`TCC_ADDR_CTRL, 16'h0000);
        wr(`TCC_ADDR_EVIO, 16'hffff);
        rd(`TCC_ADDR_EVIO, a);
        check("unlocked", a, `TCC_EV_MASK);
        tend("lock");
        wrap_run(16'h0100, 16'h0001);
        wrap_run(16'h0000, 16'h0000);
        // Compare match on channel 0, capture mode on channel 1
        swrst();
        wr(`TCC_ADDR_CAP0, 16'h0003);
        wr(`TCC_ADDR_CAP1, 16'h0003);
        wr(`TCC_ADDR_CHCTL, 16'h0020);
        wr(`TCC_ADDR_EVIO, 16'h1000);
        ch0_cnt = 0;
        wr(`TCC_ADDR_CTRL, 16'h0002);
        repeat (40) @(posedge clk_i);
        check("match events", ch0_cnt[15:0], 16'h0001);
        check("wave", {14'h0000, pins}, 16'h0001);
        wr(`TCC_ADDR_CHCTL, 16'h0023);
        repeat (2) @(posedge clk_i);
        check("inverted wave", {14'h0000, pins}, 16'h0002);
        tend("match");
        // Debug halt with the run bit, then the run bit kept through software reset
        wr(`TCC_ADDR_CTRL, 16'h0000);
        wr(`TCC_ADDR_DBG, 16'h0001);
        halt <= 1'b1;
        wr(`TCC_ADDR_CTRL, 16'h0002);
        snap(a);
        repeat (20) @(posedge clk_i);
        snap(b);
        check("debug run", {15'h0000, b == a}, 16'h0000);
        swrst();
        rd(`TCC_ADDR_DBG, a);
        check("run bit kept", a, 16'h0001);
        halt <= 1'b0;
        tend("debug");
        ev_run(16'h0000, 16'h1234);
        ev_run(16'h0022, 16'h0000);
        conclude();
    end
endmodule : tcc_ctrl_tb_top
